// [shared/eeb_pkg.sv]
// Shared constants and types for the two-wire serial memory slave.
package eeb_pkg;

    localparam int unsigned CLK_PERIOD_NS = 10;

    // Glitch rejection widths per speed grade.
    localparam int unsigned GLITCH_STD_NS = 100;
    localparam int unsigned GLITCH_FAST_NS = 50;
    localparam int unsigned GLITCH_STD_CYC = (GLITCH_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned GLITCH_FAST_CYC =
        (GLITCH_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Longest program cycle per supply variant; a longest time rounds down.
    localparam int unsigned PROG_STD_MS = 10;
    localparam int unsigned PROG_LOW_MS = 15;
    localparam int unsigned NS_PER_MS = 1000000;
    localparam int unsigned PROG_STD_CYC = PROG_STD_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int unsigned PROG_LOW_CYC = PROG_LOW_MS * NS_PER_MS / CLK_PERIOD_NS;

    // Array organisation.
    localparam int unsigned BYTE_BITS = 8;
    localparam int unsigned PAGE_BITS = 4;
    localparam int unsigned PAGE_BYTES = 16;
    localparam int unsigned MAX_SEG_BITS = 3;
    localparam int unsigned STRAP_CNT = 3;
    localparam int unsigned BIT_CNT_LAST = 8;

    // Slave address layout.
    localparam int unsigned TYPE_MSB = 7;
    localparam int unsigned TYPE_LSB = 4;
    localparam int unsigned STRAP_LSB = 1;
    localparam int unsigned RW_POS = 0;
    localparam logic RW_READ = 1'h1;
    localparam logic ACK_LEVEL = 1'h0;

    // Pin vector positions after synchronisation.
    localparam int unsigned PIN_SCL = 0;
    localparam int unsigned PIN_SDA = 1;
    localparam int unsigned PIN_STRAP0 = 2;
    localparam int unsigned PIN_GUARD = 5;
    localparam int unsigned PIN_CNT = 6;
    localparam logic [PIN_CNT-1:0] PIN_IDLE = 6'h03;

    typedef enum logic [2:0] {
        EEB_IDLE,
        EEB_RX,
        EEB_ACK,
        EEB_TX,
        EEB_TXACK
    } eeb_state_t;

    // Filtered bus lines and the conditions decoded from them.
    typedef struct packed {
        logic scl;
        logic sda;
        logic rise;
        logic fall;
        logic start;
        logic stop;
    } eeb_bus_ev_t;

endpackage

// [logic/eeb_slave_top.sv]
// Two-wire serial memory slave: bus front end, addressing, write guard and program timer.
module eeb_slave_top #(
    parameter int unsigned SEG_BITS = 0,
    parameter bit FAST_GRADE = 1'h0,
    parameter bit LOW_SUPPLY = 1'h0,
    parameter int unsigned PROG_CYCLES =
        LOW_SUPPLY ? eeb_pkg::PROG_LOW_CYC : eeb_pkg::PROG_STD_CYC,
    // Device type code; the value is arbitrary.
    parameter logic [3:0] DEV_TYPE = 4'h5
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic scl_clk_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic strap_addr_bit0_i,
    input wire logic strap_addr_bit1_i,
    input wire logic strap_addr_bit2_i,
    input wire logic guard_i,
    output logic busy_o,
    output logic standby_o
);
    import eeb_pkg::*;

    localparam int unsigned AW = BYTE_BITS + SEG_BITS;
    localparam int unsigned DEPTH = 1 << AW;
    localparam int unsigned GL_CYC = FAST_GRADE ? GLITCH_FAST_CYC : GLITCH_STD_CYC;
    localparam int unsigned GW = $clog2(GL_CYC + 1);
    localparam int unsigned CW = $clog2(PROG_CYCLES + 1);
    localparam logic [GW-1:0] GL_LAST = GW'(GL_CYC - 1);
    localparam logic [CW-1:0] PROG_LOAD = CW'(PROG_CYCLES - 1);
    localparam logic [CW-1:0] PROG_END = CW'(1);

    // Link domain: the bus clock shifts the data line in directly.
    logic [7:0] lnk_shift_r;
    logic [7:0] lnk_shift_nxt;

    always_comb begin
        lnk_shift_nxt = {lnk_shift_r[6:0], sda_i};
    end

    always_ff @(posedge scl_clk_i) begin
        lnk_shift_r <= lnk_shift_nxt;
    end

    // Pin synchronisers. The shifted word is only sampled long after the bus clock
    // edge that changed it, so a two-stage copy is stable when the FSM reads it.
    logic [PIN_CNT-1:0] sync1_r;
    logic [PIN_CNT-1:0] sync1_nxt;
    logic [PIN_CNT-1:0] sync2_r;
    logic [PIN_CNT-1:0] sync2_nxt;
    logic [7:0] word1_r;
    logic [7:0] word1_nxt;
    logic [7:0] word2_r;
    logic [7:0] word2_nxt;

    always_comb begin
        sync1_nxt = {guard_i, strap_addr_bit2_i, strap_addr_bit1_i, strap_addr_bit0_i,
                     sda_i, scl_clk_i};
        sync2_nxt = sync1_r;
        word1_nxt = lnk_shift_r;
        word2_nxt = word1_r;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            sync1_r <= PIN_IDLE;
            sync2_r <= PIN_IDLE;
            word1_r <= 8'h00;
            word2_r <= 8'h00;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            word1_r <= word1_nxt;
            word2_r <= word2_nxt;
        end
    end

    // Glitch filter: a line only changes after holding a new level for GL_CYC cycles.
    logic [1:0] flt_r;
    logic [1:0] flt_nxt;
    logic [1:0] flt_d_r;
    logic [1:0] flt_d_nxt;
    logic [GW-1:0] fcnt_r [2];
    logic [GW-1:0] fcnt_nxt [2];

    for (genvar g = 0; g < 2; g++) begin : g_flt
        always_comb begin
            flt_nxt[g] = flt_r[g];
            fcnt_nxt[g] = '0;
            if (sync2_r[g] != flt_r[g]) begin
                if (fcnt_r[g] == GL_LAST) begin
                    flt_nxt[g] = sync2_r[g];
                end else begin
                    fcnt_nxt[g] = fcnt_r[g] + GW'(1);
                end
            end
        end

        always_ff @(posedge mclk_i) begin
            if (rst_i) begin
                flt_r[g] <= 1'h1;
                fcnt_r[g] <= '0;
            end else begin
                flt_r[g] <= flt_nxt[g];
                fcnt_r[g] <= fcnt_nxt[g];
            end
        end
    end

    always_comb begin
        flt_d_nxt = flt_r;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            flt_d_r <= 2'h3;
        end else begin
            flt_d_r <= flt_d_nxt;
        end
    end

    eeb_bus_ev_t ev;

    always_comb begin
        ev.scl = flt_r[PIN_SCL];
        ev.sda = flt_r[PIN_SDA];
        ev.rise = flt_r[PIN_SCL] & ~flt_d_r[PIN_SCL];
        ev.fall = ~flt_r[PIN_SCL] & flt_d_r[PIN_SCL];
        ev.start = flt_r[PIN_SCL] & flt_d_r[PIN_SCL] & flt_d_r[PIN_SDA] & ~flt_r[PIN_SDA];
        ev.stop = flt_r[PIN_SCL] & flt_d_r[PIN_SCL] & ~flt_d_r[PIN_SDA] & flt_r[PIN_SDA];
    end

    // Slave address check against type code and the straps that this density uses.
    function automatic logic addr_match(input logic [7:0] w, input logic [2:0] straps);
        logic ok;
        ok = (w[TYPE_MSB:TYPE_LSB] == DEV_TYPE);
        for (int k = 0; k < STRAP_CNT; k++) begin
            if (k >= SEG_BITS && w[k + STRAP_LSB] != straps[k]) begin
                ok = 1'h0;
            end
        end
        return ok;
    endfunction

    // Protocol state.
    eeb_state_t st_r;
    eeb_state_t st_nxt;
    logic [3:0] bit_r;
    logic [3:0] bit_nxt;
    logic [1:0] byte_r;
    logic [1:0] byte_nxt;
    logic rw_r;
    logic rw_nxt;
    logic [AW-1:0] addr_r;
    logic [AW-1:0] addr_nxt;
    logic [7:0] pbuf_r [PAGE_BYTES];
    logic [7:0] pbuf_nxt [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] pmask_r;
    logic [PAGE_BYTES-1:0] pmask_nxt;
    logic [7:0] tx_r;
    logic [7:0] tx_nxt;
    logic sda_oe_r;
    logic sda_oe_nxt;
    logic busy_r;
    logic busy_nxt;
    logic standby_r;
    logic standby_nxt;
    logic [CW-1:0] pcnt_r;
    logic [CW-1:0] pcnt_nxt;
    logic commit;
    logic [7:0] mem_r [DEPTH];
    logic [7:0] mem_nxt [DEPTH];
    logic [7:0] rd_byte;

    assign rd_byte = mem_r[addr_r];

    always_comb begin
        st_nxt = st_r;
        bit_nxt = bit_r;
        byte_nxt = byte_r;
        rw_nxt = rw_r;
        addr_nxt = addr_r;
        pbuf_nxt = pbuf_r;
        pmask_nxt = pmask_r;
        tx_nxt = tx_r;
        sda_oe_nxt = sda_oe_r;
        busy_nxt = busy_r;
        pcnt_nxt = pcnt_r;
        commit = 1'h0;
        if (busy_r) begin
            // The whole bus interface is deaf while programming.
            st_nxt = EEB_IDLE;
            sda_oe_nxt = 1'h0;
            pcnt_nxt = pcnt_r - CW'(1);
            if (pcnt_r == PROG_END) begin
                busy_nxt = 1'h0;
            end
        end else if (ev.start) begin
            // A repeated start abandons any bytes not yet committed.
            st_nxt = EEB_RX;
            bit_nxt = 4'h0;
            byte_nxt = 2'h0;
            sda_oe_nxt = 1'h0;
            pmask_nxt = '0;
        end else if (ev.stop) begin
            st_nxt = EEB_IDLE;
            sda_oe_nxt = 1'h0;
            if (pmask_r != '0) begin
                commit = 1'h1;
                busy_nxt = 1'h1;
                pcnt_nxt = PROG_LOAD;
                pmask_nxt = '0;
            end
        end else begin
            case (st_r)
                EEB_IDLE: begin
                    sda_oe_nxt = 1'h0;
                end
                EEB_RX: begin
                    if (ev.rise && bit_r != 4'(BIT_CNT_LAST)) begin
                        bit_nxt = bit_r + 4'h1;
                    end
                    if (ev.fall && bit_r == 4'(BIT_CNT_LAST)) begin
                        bit_nxt = 4'h0;
                        if (byte_r != 2'h2) begin
                            byte_nxt = byte_r + 2'h1;
                        end
                        st_nxt = EEB_ACK;
                        sda_oe_nxt = 1'h1;
                        if (byte_r == 2'h0) begin
                            if (addr_match(word2_r, sync2_r[PIN_STRAP0 +: STRAP_CNT])) begin
                                rw_nxt = (word2_r[RW_POS] == RW_READ);
                                for (int k = 0; k < SEG_BITS; k++) begin
                                    addr_nxt[BYTE_BITS + k] = word2_r[k + STRAP_LSB];
                                end
                            end else begin
                                st_nxt = EEB_IDLE;
                                sda_oe_nxt = 1'h0;
                            end
                        end else if (byte_r == 2'h1 && !rw_r) begin
                            addr_nxt[BYTE_BITS-1:0] = word2_r;
                        end else if (!rw_r) begin
                            if (sync2_r[PIN_GUARD] && addr_r[AW-1]) begin
                                // Guarded data is refused and nothing will be programmed.
                                st_nxt = EEB_IDLE;
                                sda_oe_nxt = 1'h0;
                                pmask_nxt = '0;
                            end else begin
                                pbuf_nxt[addr_r[PAGE_BITS-1:0]] = word2_r;
                                pmask_nxt[addr_r[PAGE_BITS-1:0]] = 1'h1;
                                addr_nxt[PAGE_BITS-1:0] =
                                    addr_r[PAGE_BITS-1:0] + PAGE_BITS'(1);
                            end
                        end
                    end
                end
                EEB_ACK: begin
                    if (ev.fall) begin
                        if (rw_r) begin
                            tx_nxt = rd_byte;
                            sda_oe_nxt = ~rd_byte[7];
                            bit_nxt = 4'h0;
                            st_nxt = EEB_TX;
                        end else begin
                            sda_oe_nxt = 1'h0;
                            st_nxt = EEB_RX;
                        end
                    end
                end
                EEB_TX: begin
                    if (ev.fall) begin
                        bit_nxt = bit_r + 4'h1;
                        if (bit_r == 4'(BIT_CNT_LAST - 1)) begin
                            sda_oe_nxt = 1'h0;
                            addr_nxt = addr_r + AW'(1);
                            st_nxt = EEB_TXACK;
                        end else begin
                            tx_nxt = {tx_r[6:0], 1'h0};
                            sda_oe_nxt = ~tx_r[6];
                        end
                    end
                end
                EEB_TXACK: begin
                    if (ev.rise) begin
                        bit_nxt = {3'h0, ev.sda == ACK_LEVEL};
                    end
                    if (ev.fall) begin
                        if (bit_r[0]) begin
                            tx_nxt = rd_byte;
                            sda_oe_nxt = ~rd_byte[7];
                            bit_nxt = 4'h0;
                            st_nxt = EEB_TX;
                        end else begin
                            st_nxt = EEB_IDLE;
                        end
                    end
                end
                default: begin
                    st_nxt = EEB_IDLE;
                    sda_oe_nxt = 1'h0;
                end
            endcase
        end
        standby_nxt = (st_nxt == EEB_IDLE) && !busy_nxt;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            st_r <= EEB_IDLE;
            bit_r <= 4'h0;
            byte_r <= 2'h0;
            rw_r <= 1'h0;
            addr_r <= '0;
            pmask_r <= '0;
            tx_r <= 8'h00;
            sda_oe_r <= 1'h0;
            busy_r <= 1'h0;
            standby_r <= 1'h1;
            pcnt_r <= '0;
        end else begin
            st_r <= st_nxt;
            bit_r <= bit_nxt;
            byte_r <= byte_nxt;
            rw_r <= rw_nxt;
            addr_r <= addr_nxt;
            pmask_r <= pmask_nxt;
            tx_r <= tx_nxt;
            sda_oe_r <= sda_oe_nxt;
            busy_r <= busy_nxt;
            standby_r <= standby_nxt;
            pcnt_r <= pcnt_nxt;
        end
    end

    // Data storage carries no reset; its contents are not control state.
    always_comb begin
        mem_nxt = mem_r;
        for (int i = 0; i < PAGE_BYTES; i++) begin
            if (commit && pmask_r[i]) begin
                mem_nxt[{addr_r[AW-1:PAGE_BITS], PAGE_BITS'(i)}] = pbuf_r[i];
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        mem_r <= mem_nxt;
        pbuf_r <= pbuf_nxt;
    end

    // The pad only ever pulls low; the level register is held at zero.
    logic sda_lvl_r;

    always_ff @(posedge mclk_i) begin
        sda_lvl_r <= 1'h0;
    end

    assign sda_o = sda_lvl_r;
    assign sda_oe_o = sda_oe_r;
    assign busy_o = busy_r;
    assign standby_o = standby_r;

endmodule

// [verif/eeb_slave_sva.sv]
// Port checker for the two-wire memory slave.
module eeb_slave_sva #(
    parameter int unsigned PROG_CYCLES = 200
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic scl_clk_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic strap_addr_bit0_i,
    input wire logic strap_addr_bit1_i,
    input wire logic strap_addr_bit2_i,
    input wire logic guard_i,
    input wire logic busy_o,
    input wire logic standby_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic sda_d_r;
    logic frame_r;
    logic [7:0] rise_cnt_r;
    logic [7:0] hi_cnt_r;
    logic [31:0] busy_cnt_r;
    // A frame only ends after both lines idle high for a long time, so a rejected glitch
    // on the data line does not close it early.
    always_ff @(posedge mclk_i) begin
        sda_d_r <= sda_i;
        if (rst_i) begin
            frame_r <= 1'h0;
            rise_cnt_r <= 8'hFF;
            hi_cnt_r <= 8'h00;
            busy_cnt_r <= 32'h0;
        end else begin
            if (scl_clk_i && sda_d_r && !sda_i) frame_r <= 1'h1;
            else if (hi_cnt_r == 8'h50) frame_r <= 1'h0;
            if (scl_clk_i && !sda_d_r && sda_i) rise_cnt_r <= 8'h00;
            else if (rise_cnt_r != 8'hFF) rise_cnt_r <= rise_cnt_r + 8'h01;
            if (!(scl_clk_i && sda_i)) hi_cnt_r <= 8'h00;
            else if (hi_cnt_r != 8'hFF) hi_cnt_r <= hi_cnt_r + 8'h01;
            busy_cnt_r <= busy_o ? busy_cnt_r + 32'h1 : 32'h0;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    data_open_drain_a: assert property (sda_o == 1'h0)
        else $error("data output level not low");
    busy_quiet_a: assert property (busy_o |-> !sda_oe_o)
        else $error("data line pulled during program cycle");
    busy_standby_a: assert property (!(busy_o && standby_o))
        else $error("standby while programming");
    prog_start_a: assert property ($rose(busy_o) |-> rise_cnt_r < 8'h28)
        else $error("program cycle began without a stop");
    // The counter stops at one, so the cycle runs one short of PROG_CYCLES.
    prog_length_a: assert property ($fell(busy_o) |-> busy_cnt_r == PROG_CYCLES - 1)
        else $error("program cycle length wrong");
    data_change_low_a: assert property ($changed(sda_oe_o) |-> !scl_clk_i)
        else $error("data line changed while clock high");
    idle_no_drive_a: assert property (sda_oe_o |-> frame_r)
        else $error("data line pulled outside a frame");
    standby_after_prog_a: assert property ($fell(busy_o) |-> ##[0:2] standby_o)
        else $error("no standby after program cycle");
    cover property ($rose(sda_oe_o));
    cover property ($rose(busy_o));
    cover property ($fell(busy_o));
endmodule

// [verif/eeb_master_model.sv]
// Two-wire bus master model; the clock only runs inside its tasks.
module eeb_master_model (
    input wire logic lclk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_pull_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic glitch;
    initial begin
        scl_o = 1'h1;
        sda_pull_o = 1'h0;
        glitch = 1'h0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge lclk_i);
    endtask
    // Works from idle and, as a repeated start, from a low clock.
    task automatic start_c();
        tick(1);
        sda_pull_o = 1'h0;
        tick(1);
        scl_o = 1'h1;
        tick(2);
        sda_pull_o = 1'h1;
        tick(2);
        scl_o = 1'h0;
    endtask
    task automatic stop_c();
        tick(1);
        sda_pull_o = 1'h1;
        tick(2);
        scl_o = 1'h1;
        tick(2);
        sda_pull_o = 1'h0;
        tick(8);
    endtask
    // A requested glitch is shorter than the reject width and must be ignored.
    task automatic bit_io(input logic b, output logic r);
        // A clock already left low by the previous bit is not driven again.
        if (scl_o) scl_o = 1'h0;
        tick(1);
        sda_pull_o = !b;
        tick(3);
        scl_o = 1'h1;
        tick(1);
        if (glitch && b) begin
            sda_pull_o = 1'h1;
            #30;
            sda_pull_o = 1'h0;
            glitch = 1'h0;
        end
        tick(1);
        r = sda_i;
        tick(2);
        scl_o = 1'h0;
    endtask
    task automatic xfer(input logic [7:0] d, input logic ninth, output logic [7:0] q,
                        output logic r9);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(ninth, r9);
    endtask
endmodule

// [verif/serial_eeprom_bus_slave_bench.sv]
// Self-checking bench for the two-wire memory slave.
module serial_eeprom_bus_slave_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import eeb_pkg::*;
    localparam int unsigned PROG = 2000;
    // Device type code; the value is arbitrary.
    localparam logic [3:0] TYPE = 4'h6;
    logic mclk = 1'h0;
    logic lclk;
    logic rst = 1'h1;
    logic scl;
    logic m_pull;
    logic sda_w;
    logic sda_o_w;
    logic oe_w;
    logic [2:0] st_r = 3'h0;
    logic guard = 1'h0;
    logic busy;
    logic standby;
    logic [31:0] seed = 32'h1AF385A8;
    logic [7:0] mem [512];
    int fail_count = 0;
    int n_compared = 0;
    int cyc = 0;
    // Pull-up: the line is high unless someone pulls it low.
    assign sda_w = !(oe_w || m_pull);
    always #5 mclk = ~mclk;
    initial begin
        lclk = 1'h0;
        #3;
        forever #62.5 lclk = ~lclk;
    end
    eeb_slave_top #(.SEG_BITS(1), .FAST_GRADE(1'h1), .PROG_CYCLES(PROG), .DEV_TYPE(TYPE)) uut (
        .mclk_i(mclk), .rst_i(rst), .scl_clk_i(scl), .sda_i(sda_w), .sda_o(sda_o_w),
        .sda_oe_o(oe_w), .strap_addr_bit0_i(st_r[0]), .strap_addr_bit1_i(st_r[1]),
        .strap_addr_bit2_i(st_r[2]), .guard_i(guard), .busy_o(busy), .standby_o(standby));
    eeb_master_model mst (.lclk_i(lclk), .sda_i(sda_w), .scl_o(scl), .sda_pull_o(m_pull));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic addr_ok(input logic [7:0] a);
        return a[7:4] == TYPE && a[3:2] == st_r[2:1];
    endfunction
    task automatic end_of_test();
        $display("Compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic set_pins(input logic [2:0] st, input logic g);
        @(posedge mclk);
        #1;
        st_r = st;
        guard = g;
        repeat (4) @(posedge mclk);
    endtask
    task automatic page_wr(input logic seg, input logic [7:0] wa, input int n, input logic g);
        logic [7:0] q;
        logic r;
        logic [7:0] d;
        logic ok;
        ok = !(g && seg);
        set_pins(st_r, g);
        mst.start_c();
        mst.xfer({TYPE, st_r[2:1], seg, 1'h0}, 1'h1, q, r);
        check("addr_ack", r, 1'h0);
        mst.xfer(wa, 1'h1, q, r);
        check("word_ack", r, 1'h0);
        for (int i = 0; i < n; i++) begin
            seed = xs(seed);
            d = seed[7:0];
            mst.xfer(d, 1'h1, q, r);
            check("data_ack", r, !ok);
            if (ok) mem[{seg, wa[7:4], wa[3:0] + i[3:0]}] = d;
        end
        mst.stop_c();
        check("busy_after_stop", busy, ok);
        check("standby", standby, !ok);
        if (ok) begin
            mst.start_c();
            mst.xfer({TYPE, st_r[2:1], seg, 1'h0}, 1'h1, q, r);
            check("poll_nack", r, 1'h1);
            mst.stop_c();
            for (int k = 0; k < 3000 && busy !== 1'h0; k++) @(posedge mclk);
            #1;
            check("busy_end", busy, 1'h0);
            check("standby_end", standby, 1'h1);
        end
    endtask
    task automatic rd_chk(input logic seg, input logic [7:0] wa, input int n);
        logic [7:0] q;
        logic r;
        mst.start_c();
        mst.xfer({TYPE, st_r[2:1], seg, 1'h0}, 1'h1, q, r);
        mst.xfer(wa, 1'h1, q, r);
        mst.start_c();
        mst.xfer({TYPE, st_r[2:1], seg, 1'h1}, 1'h1, q, r);
        check("rd_addr_ack", r, 1'h0);
        for (int i = 0; i < n; i++) begin
            mst.xfer(8'hFF, i == n - 1, q, r);
            check("rd_data", q, mem[{seg, wa + i[7:0]}]);
        end
        mst.stop_c();
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 90000) begin
            fail_count++;
            end_of_test();
        end
    end
    initial begin
        logic [7:0] q;
        logic r;
        logic [7:0] a;
        repeat (4) @(posedge mclk);
        #1;
        rst = 1'h0;
        repeat (30) @(posedge mclk);
        #1;
        check("oe_reset", oe_w, 1'h0);
        check("busy_reset", busy, 1'h0);
        check("standby_reset", standby, 1'h1);
        // Random straps with a mix of matching, mismatching and wrong-type addresses.
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            set_pins(seed[2:0], seed[3]);
            a = {TYPE, seed[4] ? st_r[2:1] : seed[6:5], seed[7], 1'h0};
            if (i == 0) a[7:4] = ~TYPE;
            mst.start_c();
            mst.xfer(a, 1'h1, q, r);
            mst.stop_c();
            check("strap_ack", r, !addr_ok(a));
        end
        page_wr(1'h0, 8'h3E, 17, 1'h1);
        rd_chk(1'h0, 8'h30, 16);
        seed = xs(seed);
        page_wr(1'h1, seed[7:0], 1, 1'h1);
        page_wr(1'h1, 8'h57, 3, 1'h0);
        set_pins(st_r, 1'h1);
        rd_chk(1'h1, 8'h57, 3);
        mst.glitch = 1'h1;
        mst.start_c();
        mst.xfer({TYPE, st_r[2:1], 2'h0}, 1'h1, q, r);
        mst.stop_c();
        check("glitch_ack", r, 1'h0);
        mst.xfer({TYPE, st_r[2:1], 2'h0}, 1'h1, q, r);
        mst.stop_c();
        check("no_start_nack", r, 1'h1);
        end_of_test();
    end
endmodule
bind eeb_slave_top eeb_slave_sva #(.PROG_CYCLES(PROG_CYCLES)) chk (
    .mclk_i(mclk_i), .rst_i(rst_i), .scl_clk_i(scl_clk_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .strap_addr_bit0_i(strap_addr_bit0_i),
    .strap_addr_bit1_i(strap_addr_bit1_i), .strap_addr_bit2_i(strap_addr_bit2_i),
    .guard_i(guard_i), .busy_o(busy_o), .standby_o(standby_o));
